// >>> rtl/addr_map_defines.svh
`ifndef ADDR_MAP_DEFINES_SVH
`define ADDR_MAP_DEFINES_SVH
// register indices; the bus byte offset is index*4
`define OFS_RAM_POS      8'h10
`define OFS_REG_POS      8'h11
`define OFS_EE_POS       8'h12
`define OFS_MISC         8'h13
// field positions
`define EE_ON_BIT        0
`define REG_WAIT_BIT     0
`define MISC_SWAP_BIT    7
`define MISC_NARROW_BIT  6
`define MISC_FSTR_LSB    4
`define MISC_XSTR_LSB    2
`define MISC_ARR28_BIT   1
`define MISC_ARR32_BIT   0
// reset values
`define RST_RAM_POS      8'h00
`define RST_REG_POS      8'h00
`define RST_EE_POS       8'h01
`define RST_MISC_EXP     8'h0c
`define RST_MISC_SC      8'h0f
// fixed windows
`define DEBUG_ROM_BASE   16'hff20
`define ARR28_LO_NORM    16'h1000
`define ARR28_LO_SWAP    16'h9000
`endif

// >>> rtl/addr_map_pkg.sv
package addr_map_pkg;
	typedef enum logic [2:0] {
		TGT_EXTERNAL, TGT_DEBUG_ROM, TGT_REGS, TGT_RAM, TGT_EEPROM, TGT_ARRAY28, TGT_ARRAY32, TGT_NONE
	} target_t;
	typedef struct packed {
		target_t    target;
		logic [1:0] stretch;
		logic       narrow;
		logic       followSpace;
	} decode_t;
	typedef struct packed {
		logic expanded;
		logic special;
		logic wideBus;
		logic debugActive;
		logic waitMode;
	} mode_t;
endpackage : addr_map_pkg

// >>> rtl/internal_resource_address_map.sv
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "addr_map_defines.svh"
module internal_resource_address_map #(
	parameter int ADDR_W = 16
) (
	input  wire logic                    core_clk,
	input  wire logic                    nrst,
	input  wire addr_map_pkg::mode_t     mode,
	input  wire logic [ADDR_W-1:0]       busAddr,
	input  wire logic                    busValid,
	output addr_map_pkg::decode_t        decode,
	output logic                         decodeValid,
	input  wire logic                    awvalid,
	output logic                         awready,
	input  wire logic [31:0]             awaddr,
	input  wire logic [2:0]              awprot,
	input  wire logic                    wvalid,
	output logic                         wready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	output logic                         bvalid,
	input  wire logic                    bready,
	output logic [1:0]                   bresp,
	input  wire logic                    arvalid,
	output logic                         arready,
	input  wire logic [31:0]             araddr,
	input  wire logic [2:0]              arprot,
	output logic                         rvalid,
	input  wire logic                    rready,
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp
);
	// ========================================
	// elaboration checks
	if (ADDR_W != 16) begin : g_addr_w_chk
		$error("address width must be 16");
	end

	// ========================================
	// reset synchroniser
	logic rstSync1_r;
	logic rstSync2_r;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rstSync1_r <= 1'b0;
			rstSync2_r <= 1'b0;
		end else begin
			rstSync1_r <= 1'b1;
			rstSync2_r <= rstSync1_r;
		end
	end
	// only the second stage is read; the first may still be settling
	wire logic rstN = rstSync2_r;

	// ========================================
	// bus slave
	logic        awHeld_r;
	logic        awHeld_nxt;
	logic        wHeld_r;
	logic        wHeld_nxt;
	logic [7:0]  awOfs_r;
	logic [7:0]  awOfs_nxt;
	logic [31:0] wData_r;
	logic [31:0] wData_nxt;
	logic        wStrb0_r;
	logic        wStrb0_nxt;
	logic        bvalid_r;
	logic        bvalid_nxt;
	logic [1:0]  bresp_r;
	logic [1:0]  bresp_nxt;
	logic        rvalid_r;
	logic        rvalid_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [1:0]  rresp_r;
	logic [1:0]  rresp_nxt;
	logic        doWrite;
	logic        wrHit;
	logic        rdHit;

	// address lies in the 2K block named by a five-bit position field
	function automatic logic inBlock2k(input logic [15:0] a, input logic [4:0] pos);
		inBlock2k = a[15:11] == pos;
	endfunction : inBlock2k

	// ========================================
	// mapping registers
	logic [7:0] ramPos_r;
	logic [7:0] ramPos_nxt;
	logic [7:0] regPos_r;
	logic [7:0] regPos_nxt;
	logic [7:0] eePos_r;
	logic [7:0] eePos_nxt;
	logic [7:0] misc_r;
	logic [7:0] misc_nxt;
	logic       ramDone_r;
	logic       ramDone_nxt;
	logic       regDone_r;
	logic       regDone_nxt;
	logic       eeDone_r;
	logic       eeDone_nxt;
	logic       miscDone_r;
	logic       miscDone_nxt;
	logic       miscInit_r;
	logic       miscInit_nxt;

	// register offsets 0x11-0x13 are not word aligned, so index*4 addressing
	function automatic logic [7:0] byteAddr(input logic [7:0] idx);
		byteAddr = {idx[5:0], 2'b00};
	endfunction : byteAddr

	function automatic logic [7:0] readReg(
		input logic [7:0] a,
		input logic [7:0] rp,
		input logic [7:0] gp,
		input logic [7:0] ep,
		input logic [7:0] mc
	);
		if (a == byteAddr(`OFS_RAM_POS)) readReg = rp;
		else if (a == byteAddr(`OFS_REG_POS)) readReg = gp;
		else if (a == byteAddr(`OFS_EE_POS)) readReg = ep;
		else readReg = mc;
	endfunction : readReg

	function automatic logic inMap(input logic [31:0] a);
		inMap = a[31:8] == 24'h0 && a[1:0] == 2'b00 && a[7:6] == 2'b01 && a[5:2] <= 4'h3;
	endfunction : inMap

	always_comb begin
		awHeld_nxt = awHeld_r;
		wHeld_nxt  = wHeld_r;
		awOfs_nxt  = awOfs_r;
		wData_nxt  = wData_r;
		wStrb0_nxt = wStrb0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt  = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (awvalid && awready) begin
			awHeld_nxt = 1'b1;
			// unmapped address kept as 8'hff so the answer can refuse it
			awOfs_nxt  = inMap(awaddr) ? awaddr[7:0] : 8'hff;
		end
		if (wvalid && wready) begin
			wHeld_nxt  = 1'b1;
			wData_nxt  = wdata;
			wStrb0_nxt = wstrb[0];
		end
		if (doWrite) begin
			awHeld_nxt = 1'b0;
			wHeld_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = wrHit ? 2'b00 : 2'b10;
		end else if (bvalid_r && bready) begin
			bvalid_nxt = 1'b0;
		end
		if (arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = rdHit ? 2'b00 : 2'b10;
			rdata_nxt  = rdHit ?
				{24'h0, readReg(araddr[7:0], ramPos_r, regPos_r, eePos_r, misc_r)} : 32'h0;
		end else if (rvalid_r && rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			awHeld_r <= 1'b0;
			wHeld_r  <= 1'b0;
			awOfs_r  <= 8'h00;
			wData_r  <= 32'h0;
			wStrb0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r  <= 2'b00;
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0;
			rresp_r  <= 2'b00;
		end else begin
			awHeld_r <= awHeld_nxt;
			wHeld_r  <= wHeld_nxt;
			awOfs_r  <= awOfs_nxt;
			wData_r  <= wData_nxt;
			wStrb0_r <= wStrb0_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r  <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r  <= rdata_nxt;
			rresp_r  <= rresp_nxt;
		end
	end

	// one write in flight: readies stay low until the answer is taken
	assign awready = !awHeld_r && !bvalid_r;
	assign wready  = !wHeld_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
	assign wrHit   = awOfs_r != 8'hff;
	assign rdHit   = inMap(araddr);
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;

	// ========================================
	// register writes
	logic       wrLane;
	logic [7:0] wByte;
	// only lane 0 carries register bits; without it the write changes nothing
	assign wrLane = doWrite && wrHit && wStrb0_r;
	assign wByte  = wData_r[7:0];

	always_comb begin
		ramPos_nxt   = ramPos_r;
		regPos_nxt   = regPos_r;
		eePos_nxt    = eePos_r;
		misc_nxt     = misc_r;
		ramDone_nxt  = ramDone_r;
		regDone_nxt  = regDone_r;
		eeDone_nxt   = eeDone_r;
		miscDone_nxt = miscDone_r;
		miscInit_nxt = 1'b1;
		// mode-dependent reset value of misc taken one cycle after release
		if (!miscInit_r) misc_nxt = mode.expanded ? `RST_MISC_EXP : `RST_MISC_SC;
		// done flags lock a register even when the value written is unchanged
		if (wrLane && awOfs_r == byteAddr(`OFS_RAM_POS) && (mode.special || !ramDone_r)) begin
			ramPos_nxt  = {wByte[7:3], 3'b000};
			ramDone_nxt = 1'b1;
		end
		if (wrLane && awOfs_r == byteAddr(`OFS_REG_POS)) begin
			if (mode.special || !regDone_r) begin
				regPos_nxt[7:3] = wByte[7:3];
				regDone_nxt     = 1'b1;
			end
			// wait-stop bit sits outside the once-only lock, with its own rule
			if (!mode.special) regPos_nxt[`REG_WAIT_BIT] = wByte[`REG_WAIT_BIT];
		end
		if (wrLane && awOfs_r == byteAddr(`OFS_EE_POS)) begin
			if (mode.special || !eeDone_r) begin
				eePos_nxt[7:4] = wByte[7:4];
				eeDone_nxt     = 1'b1;
			end
			eePos_nxt[`EE_ON_BIT] = wByte[`EE_ON_BIT];
		end
		if (wrLane && awOfs_r == byteAddr(`OFS_MISC) && (mode.special || !miscDone_r)) begin
			misc_nxt     = wByte;
			miscDone_nxt = 1'b1;
		end
		if (!mode.expanded) eePos_nxt[`EE_ON_BIT] = 1'b1;
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			ramPos_r   <= `RST_RAM_POS;
			regPos_r   <= `RST_REG_POS;
			eePos_r    <= `RST_EE_POS;
			// single-chip value until the mode is seen one cycle after release
			misc_r     <= `RST_MISC_SC;
			ramDone_r  <= 1'b0;
			regDone_r  <= 1'b0;
			eeDone_r   <= 1'b0;
			miscDone_r <= 1'b0;
			miscInit_r <= 1'b0;
		end else begin
			ramPos_r   <= ramPos_nxt;
			regPos_r   <= regPos_nxt;
			eePos_r    <= eePos_nxt;
			misc_r     <= misc_nxt;
			ramDone_r  <= ramDone_nxt;
			regDone_r  <= regDone_nxt;
			eeDone_r   <= eeDone_nxt;
			miscDone_r <= miscDone_nxt;
			miscInit_r <= miscInit_nxt;
		end
	end

	// ========================================
	// address decode
	logic        mapWaitStop;
	logic        arraySwap;
	logic        followNarrow;
	logic [1:0]  followStretch;
	logic [1:0]  extStretch;
	logic        arr28On;
	logic        arr32On;
	logic        hitDbg;
	logic        hitReg;
	logic        hitFollow;
	logic        hitRam;
	logic        hitEe;
	logic        hit28;
	logic        hit32;
	addr_map_pkg::decode_t decode_nxt;
	addr_map_pkg::decode_t decode_r;
	logic        decodeValid_r;
	logic        decodeValid_nxt;

	assign mapWaitStop   = regPos_r[`REG_WAIT_BIT];
	assign arraySwap     = misc_r[`MISC_SWAP_BIT];
	assign followNarrow  = misc_r[`MISC_NARROW_BIT];
	assign followStretch = misc_r[`MISC_FSTR_LSB +: 2];
	assign extStretch    = misc_r[`MISC_XSTR_LSB +: 2];
	assign arr28On       = misc_r[`MISC_ARR28_BIT];
	assign arr32On       = misc_r[`MISC_ARR32_BIT];

	// decode reads live registers, so a write shows on the next cycle
	always_comb begin
		hitDbg    = mode.debugActive && busAddr >= `DEBUG_ROM_BASE;
		hitReg    = inBlock2k(busAddr, regPos_r[7:3]) && busAddr[10:9] == 2'b00;
		hitFollow = inBlock2k(busAddr, regPos_r[7:3]) && busAddr[10:9] == 2'b01;
		hitRam    = inBlock2k(busAddr, ramPos_r[7:3]);
		// eeprom fills the top 1K of its 4K block
		hitEe     = eePos_r[`EE_ON_BIT] && busAddr[15:12] == eePos_r[7:4] && busAddr[11:10] == 2'b11;
		// swapped: 32K takes the low half, 28K the top 28K
		hit28     = arr28On && (arraySwap ? busAddr >= `ARR28_LO_SWAP :
			(busAddr >= `ARR28_LO_NORM && !busAddr[15]));
		hit32     = arr32On && (arraySwap ? !busAddr[15] : busAddr[15]);
		decode_nxt             = '0;
		decode_nxt.target      = addr_map_pkg::TGT_NONE;
		decode_nxt.followSpace = 1'b0;
		// chain order is the priority; a lower hit under a higher one is lost
		if (hitDbg) decode_nxt.target = addr_map_pkg::TGT_DEBUG_ROM;
		else if (hitReg) decode_nxt.target = addr_map_pkg::TGT_REGS;
		else if (hitRam) decode_nxt.target = addr_map_pkg::TGT_RAM;
		else if (hitEe) decode_nxt.target = addr_map_pkg::TGT_EEPROM;
		else if (hit28) decode_nxt.target = addr_map_pkg::TGT_ARRAY28;
		else if (hit32) decode_nxt.target = addr_map_pkg::TGT_ARRAY32;
		else if (mode.expanded) begin
			decode_nxt.target = addr_map_pkg::TGT_EXTERNAL;
			if (hitFollow) begin
				decode_nxt.followSpace = 1'b1;
				decode_nxt.stretch     = followStretch;
				decode_nxt.narrow      = followNarrow && mode.wideBus;
			end else begin
				decode_nxt.stretch = extStretch;
			end
		end
		// wait mode with stop bit set suspends decoding
		decodeValid_nxt = busValid && !(mode.waitMode && mapWaitStop);
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			decode_r      <= '{target: addr_map_pkg::TGT_NONE, stretch: 2'b00, narrow: 1'b0, followSpace: 1'b0};
			decodeValid_r <= 1'b0;
		end else begin
			decode_r      <= decode_nxt;
			decodeValid_r <= decodeValid_nxt;
		end
	end

	assign decode      = decode_r;
	assign decodeValid = decodeValid_r;
endmodule : internal_resource_address_map

// >>> tb/cpu_bus_model.sv
`timescale 1ns/10ps
module cpu_bus_model (
	input  wire logic        core_clk,
	output logic [15:0]      busAddr,
	output logic             busValid
);
	initial begin
		busAddr = 16'hffff;
		busValid = 1'b0;
	end
	// ==========
	// idle edge first, like a nop after a mapping write
	task access(input logic [15:0] a);
		@(posedge core_clk);
		busAddr  <= a;
		busValid <= 1'b1;
		@(posedge core_clk);
		busValid <= 1'b0;
		busAddr  <= ~a;
	endtask : access
endmodule : cpu_bus_model

// >>> tb/addr_map_chk.sv
`timescale 1ns/10ps
module addr_map_chk #(
	parameter int ADDR_W = 16
) (
	input wire logic                  core_clk,
	input wire logic                  nrst,
	input wire addr_map_pkg::mode_t   mode,
	input wire logic [ADDR_W-1:0]     busAddr,
	input wire logic                  busValid,
	input wire addr_map_pkg::decode_t decode,
	input wire logic                  decodeValid,
	input wire logic                  awvalid,
	input wire logic                  awready,
	input wire logic                  wvalid,
	input wire logic                  wready,
	input wire logic                  bvalid,
	input wire logic                  arvalid,
	input wire logic                  arready,
	input wire logic [31:0]           araddr,
	input wire logic                  rvalid,
	input wire logic [31:0]           rdata,
	input wire logic [1:0]            rresp
);
	logic hit;
	assign hit = araddr inside {32'h40, 32'h44, 32'h48, 32'h4c};
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// ==========
	// bus answers
	sequence s_rd(b); arvalid && arready && hit == b; endsequence
	sequence s_wr; awvalid && awready && wvalid && wready; endsequence
	property p_rd_bad; s_rd(1'b0) |=> rvalid && rresp == 2'b10 && rdata == 32'h0; endproperty
	property p_rd_ok; s_rd(1'b1) |=> rvalid && rresp == 2'b00 && rdata[31:8] == 24'h0; endproperty
	property p_wr_ans; s_wr |=> ##1 bvalid; endproperty
	property p_refuse; bvalid |-> !awready && !wready; endproperty
	a_rd_bad: assert property (p_rd_bad) else $error("bad read answer");
	a_rd_ok: assert property (p_rd_ok) else $error("read answer wrong");
	a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
	a_refuse: assert property (p_refuse) else $error("write taken while busy");
	// ==========
	// decode
	property p_valid; !mode.waitMode && !$past(mode.waitMode) |-> decodeValid == $past(busValid); endproperty
	property p_debug;
		busValid && !mode.waitMode && mode.debugActive && busAddr >= 16'hff20
		|=> decode.target == addr_map_pkg::TGT_DEBUG_ROM;
	endproperty
	property p_single; busValid && !mode.expanded |=> decode.target != addr_map_pkg::TGT_EXTERNAL; endproperty
	property p_int_str;
		decodeValid && decode.target != addr_map_pkg::TGT_EXTERNAL && decode.target != addr_map_pkg::TGT_NONE
		|-> decode.stretch == 2'b00;
	endproperty
	a_valid: assert property (p_valid) else $error("decode valid lost");
	a_debug: assert property (p_debug) else $error("debug window missed");
	a_single: assert property (p_single) else $error("external in single chip");
	a_int_str: assert property (p_int_str) else $error("stretch on internal");
endmodule : addr_map_chk
bind internal_resource_address_map addr_map_chk #(.ADDR_W(ADDR_W)) chk_u (.core_clk, .nrst, .mode, .busAddr,
	.busValid, .decode, .decodeValid, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
	.araddr, .rvalid, .rdata, .rresp);

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
	logic core_clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic busValid, decodeValid, awready, wready, bvalid, arready, rvalid;
	addr_map_pkg::mode_t   mode;
	addr_map_pkg::decode_t decode;
	logic [15:0] busAddr;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [6:0]  e;
	logic [6:0]  decQ[$];
	logic [33:0] respQ[$];
	int num_errors = 0;
	int checks = 0;
	int i;
	internal_resource_address_map dut_u (.core_clk, .nrst, .mode, .busAddr, .busValid, .decode,
		.decodeValid, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp);
	cpu_bus_model cpu_u (.core_clk, .busAddr, .busValid);
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// ==========
	// checking
	task chk(input string n, input logic [33:0] s, ex);
		checks++;
		if (s !== ex) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, ex, s);
		end
	endtask : chk
	task summarize;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	task tmo;
		num_errors++;
		$display("Error handshake expected answer seen none");
		summarize();
	endtask : tmo
	always @(posedge core_clk) begin
		if (decodeValid === 1'b1) begin
			if (decQ.size() == 0) chk("stray decode", 34'h1, 34'h0);
			else begin
				e = decQ.pop_front();
				if (e[6:4] == addr_map_pkg::TGT_EXTERNAL) chk("decode", 34'(decode), 34'(e));
				else chk("target", 34'(decode.target), 34'(e[6:4]));
			end
		end
		if (bvalid === 1'b1 && bready) chk("bresp", {bresp, 32'h0}, respQ.pop_front());
		if (rvalid === 1'b1 && rready) chk("read", {rresp, rdata}, respQ.pop_front());
	end
	// ==========
	// drivers
	task acc(input logic [15:0] a, input addr_map_pkg::target_t t, input logic [3:0] x = 4'h0);
		decQ.push_back({t, x});
		cpu_u.access(a);
	endtask : acc
	task md(input logic [4:0] m);
		@(posedge core_clk);
		mode <= addr_map_pkg::mode_t'(m);
	endtask : md
	task wr(input logic [31:0] a, d, input logic [1:0] r = 2'b00, input logic [3:0] s = 4'hf);
		int n;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		respQ.push_back({r, 32'h0});
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		if (n == 50) tmo();
	endtask : wr
	task rd(input logic [31:0] a, d, input logic [1:0] r = 2'b00);
		int n;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		respQ.push_back({r, d});
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		if (n == 50) tmo();
	endtask : rd
	// ==========
	// main sequence; mode bits are expanded, special, wide, debug, wait
	initial begin
		mode = addr_map_pkg::mode_t'(5'h14);
		{nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'hf;
		void'($urandom(81));
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(32'h40, 32'h00);
		rd(32'h44, 32'h00);
		rd(32'h48, 32'h01);
		rd(32'h4c, 32'h0c);
		rd(32'h50, 32'h00, 2'b10);
		acc(16'h01ff, addr_map_pkg::TGT_REGS);
		acc(16'h0200, addr_map_pkg::TGT_RAM);
		acc(16'h0c00, addr_map_pkg::TGT_EEPROM);
		acc(16'h1000, addr_map_pkg::TGT_EXTERNAL, 4'hc);
		$display("test reset map done");
		wr(32'h44, 32'h09);
		wr(32'h4c, 32'h5b);
		wr(32'h48, 32'h00);
		wr(32'h40, 32'h00);
		wr(32'h40, 32'h08);
		wr(32'h4c, 32'h00);
		wr(32'h50, 32'h00, 2'b10);
		rd(32'h40, 32'h00);
		rd(32'h44, 32'h09);
		rd(32'h4c, 32'h5b);
		acc(16'h0000, addr_map_pkg::TGT_RAM);
		acc(16'h0800, addr_map_pkg::TGT_REGS);
		acc(16'h0a00, addr_map_pkg::TGT_EXTERNAL, 4'h7);
		acc(16'h0c00, addr_map_pkg::TGT_EXTERNAL, 4'h8);
		acc(16'h8000, addr_map_pkg::TGT_ARRAY32);
		for (i = 0; i < 8; i++) acc(16'($urandom_range(32'h7fff, 32'h1000)), addr_map_pkg::TGT_ARRAY28);
		$display("test relocation done");
		md(5'h15);
		cpu_u.access(16'h0800);
		md(5'h14);
		$display("test wait stop done");
		md(5'h1c);
		wr(32'h44, 32'h00);
		rd(32'h44, 32'h01);
		wr(32'h40, 32'h10, 2'b00, 4'he);
		rd(32'h40, 32'h00);
		wr(32'h4c, 32'h83);
		acc(16'h0000, addr_map_pkg::TGT_REGS);
		acc(16'h9000, addr_map_pkg::TGT_ARRAY28);
		acc(16'h1000, addr_map_pkg::TGT_ARRAY32);
		acc(16'h8fff, addr_map_pkg::TGT_EXTERNAL);
		md(5'h1e);
		acc(16'hff20, addr_map_pkg::TGT_DEBUG_ROM);
		acc(16'hff1f, addr_map_pkg::TGT_ARRAY28);
		$display("test special and debug done");
		md(5'h0c);
		acc(16'h0c00, addr_map_pkg::TGT_EEPROM);
		acc(16'h8800, addr_map_pkg::TGT_NONE);
		$display("test single chip done");
		md(5'h18);
		wr(32'h44, 32'h10);
		wr(32'h4c, 32'h40);
		acc(16'h1200, addr_map_pkg::TGT_EXTERNAL, 4'h1);
		$display("test narrow bus done");
		repeat (4) @(posedge core_clk);
		chk("pending", 34'(decQ.size() + respQ.size()), 34'h0);
		summarize();
	end
endmodule : tb
